// ---- rtl/tbint_params.svh ----
`ifndef TBINT_PARAMS_SVH
`define TBINT_PARAMS_SVH

// Register offsets on the plain register port
`define TBINT_A_TBCFG    4'h0
`define TBINT_A_INTC0    4'h1
`define TBINT_A_INTC1    4'h2
`define TBINT_A_MFI0     4'h3
`define TBINT_A_MFI1     4'h4
`define TBINT_A_MFI2     4'h5
`define TBINT_A_STAT     4'h6

// Time-base configuration fields and reset value
`define TBINT_B_ON       7
`define TBINT_B_CK       6
`define TBINT_B_T1HI     5
`define TBINT_B_T1LO     4
`define TBINT_B_LP       3
`define TBINT_B_T0HI     2
`define TBINT_B_T0LO     0
`define TBINT_TBCFG_RST  8'h37

// Flag and enable positions in the flag/enable registers
`define TBINT_B_FLAG_A   5
`define TBINT_B_FLAG_B   4
`define TBINT_B_EN_A     1
`define TBINT_B_EN_B     0

// INTC0: global enable and interrupt enables
`define TBINT_B_GIE      0
`define TBINT_B_ADE      1
`define TBINT_B_MF0E     2
`define TBINT_B_MF1E     3
`define TBINT_B_MF2E     4
`define TBINT_B_TICK0_INT_ENABLE     5
`define TBINT_B_TICK1_INT_ENABLE     6

// INTC1 flag positions
`define TBINT_B_ADF      0
`define TBINT_B_MF0F     1
`define TBINT_B_MF1F     2
`define TBINT_B_MF2F     3
`define TBINT_B_TICK0_REQUEST_FLAG     4
`define TBINT_B_TICK1_REQUEST_FLAG     5

// Divider sizes and overflow bases
`define TBINT_DIV_W      15
`define TBINT_T0_BASE    8
`define TBINT_T1_BASE    12
`define TBINT_PRE_W      2

// Vector addresses, lowest served first
`define TBINT_V_MF0      12'h004
`define TBINT_V_MF1      12'h008
`define TBINT_V_AD       12'h00C
`define TBINT_V_MF2      12'h010
`define TBINT_V_TB0      12'h014
`define TBINT_V_TB1      12'h018

`endif

// ---- rtl/tbint_pkg.sv ----
package tbint_pkg;
   typedef enum logic [2:0]
   {
      TBINT_SRC_MF0 = 3'h0,
      TBINT_SRC_MF1 = 3'h1,
      TBINT_SRC_AD  = 3'h2,
      TBINT_SRC_MF2 = 3'h3,
      TBINT_SRC_TB0 = 3'h4,
      TBINT_SRC_TB1 = 3'h5,
      TBINT_SRC_NONE = 3'h7
   } tbint_src_t;

   typedef enum logic [1:0]
   {
      TBINT_ST_RUN  = 2'h0,
      TBINT_ST_TAKE = 2'h1,
      TBINT_ST_SLP  = 2'h2
   } tbint_state_t;
endpackage

// ---- rtl/tbint_core.sv ----
// Contract
// - Divider overflow sets its time-base flag
// - Time-base vectors need global, own enable, stack
// - Time-base service clears flag and global enable
// - Bit 6 picks tick clock or sysclk/4
// - Bits 5:4 set tick1 period 4096..32768
// - Bits 2:0 set tick0 period 256..32768
// - Bit 3 crystal low power, variant only
// - Enabled member flags set combined flag
// - Combined service clears only combined, global
// - Conversion flag vectors, auto cleared
// - Timer match flags need own, combined enable
// - EEPROM write flag, not cleared on service
// - Low supply flag stays after service
// - Rising flag wakes SLEEP or IDLE
// - Flags hold until serviced or cleared
// - Entry pushes only program counter
// - Interrupt exit sets global, plain return not
// - Vector address loaded after push
// - Global enable off blocks all, flags recorded
//
// Decided for this implementation: the plain strobed port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "tbint_params.svh"

module tbint_core
   import tbint_pkg::*;
#(
   parameter bit HAS_CRYSTAL = 1'b1
)
(
   // Clock, reset, enable
   input  wire logic        mclk,
   input  wire logic        rst_n,
   input  wire logic        ce,
   // Register port
   input  wire logic [3:0]  reg_addr,
   input  wire logic [7:0]  reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic      [7:0]  reg_rdata,
   // Clock sources and event inputs
   input  wire logic        tick_clk_pulse,
   input  wire logic        t0_period_match,
   input  wire logic        t0_cmpa_match,
   input  wire logic        t1_period_match,
   input  wire logic        t1_cmpa_match,
   input  wire logic        eeprom_write_done,
   input  wire logic        low_supply_detect,
   input  wire logic        conversion_done,
   // Program sequencer
   input  wire logic        stack_full,
   input  wire logic        int_ack,
   input  wire logic        interrupt_exit,
   input  wire logic        subroutine_exit,
   input  wire logic        sleep_enter,
   output logic             int_req,
   output logic      [11:0] int_vector,
   output logic             push_pc,
   output logic             pop_pc,
   output logic             wake_up,
   output logic             slow_crystal_low_power
);

   logic [7:0]         time_base_cfg_q;
   logic               global_int_enable_q;
   logic               conversion_int_enable_q;
   logic               conversion_done_flag_q;
   logic [2:0]         combined_int_enable_q;
   logic [2:0]         combined_request_flag_q;
   logic               tick0_int_enable_q;
   logic               tick1_int_enable_q;
   logic               tick0_request_flag_q;
   logic               tick1_request_flag_q;
   logic [1:0]         timer_period_match_flag_q;
   logic [1:0]         timer_cmpa_match_flag_q;
   logic [1:0]         timer_period_match_enable_q;
   logic [1:0]         timer_cmpa_match_enable_q;
   logic               eeprom_write_done_flag_q;
   logic               eeprom_write_int_enable_q;
   logic               low_supply_request_flag_q;
   logic               low_supply_int_enable_q;
   logic [`TBINT_PRE_W-1:0] pre_q;
   logic [`TBINT_DIV_W-1:0] div_q;
   logic [`TBINT_DIV_W-1:0] div_d;
   logic               tb_clk;
   logic               ovf0;
   logic               ovf1;
   logic [11:0]        flags;
   logic [11:0]        flags_q;
   logic [2:0]         member;
   tbint_src_t         pick;
   tbint_src_t         taken_q;
   tbint_state_t       state_q;
   logic               wr_cfg;
   logic               wr_c0;
   logic               wr_c1;
   logic               wr_m0;
   logic               wr_m1;
   logic               wr_m2;
   logic               svc;
   logic [7:0]         rd_d;

   assign wr_cfg = reg_wr && reg_addr == `TBINT_A_TBCFG;
   assign wr_c0  = reg_wr && reg_addr == `TBINT_A_INTC0;
   assign wr_c1  = reg_wr && reg_addr == `TBINT_A_INTC1;
   assign wr_m0  = reg_wr && reg_addr == `TBINT_A_MFI0;
   assign wr_m1  = reg_wr && reg_addr == `TBINT_A_MFI1;
   assign wr_m2  = reg_wr && reg_addr == `TBINT_A_MFI2;
   assign svc    = ce && state_q == TBINT_ST_RUN && int_req && int_ack;

   // Time-base configuration register
   always_ff @(posedge mclk)
   begin
      if (!rst_n)
         time_base_cfg_q <= `TBINT_TBCFG_RST;
      else if (ce && wr_cfg)
      begin
         time_base_cfg_q <= reg_wdata;
         if (!HAS_CRYSTAL)
            time_base_cfg_q[`TBINT_B_LP] <= 1'b0;
      end
   end

   always_ff @(posedge mclk)
   begin
      if (!rst_n)
         slow_crystal_low_power <= 1'b0;
      else if (ce)
         slow_crystal_low_power <= time_base_cfg_q[`TBINT_B_LP];
   end

   // Clock source select: tick clock or system clock divided by four
   always_ff @(posedge mclk)
   begin
      if (!rst_n)
         pre_q <= '0;
      else if (ce)
         pre_q <= pre_q + 1'b1;
   end

   assign tb_clk = time_base_cfg_q[`TBINT_B_CK] ? (pre_q == '1) : tick_clk_pulse;
   assign div_d  = div_q + 1'b1;

   always_ff @(posedge mclk)
   begin
      if (!rst_n)
         div_q <= '0;
      else if (ce && !time_base_cfg_q[`TBINT_B_ON])
         div_q <= '0;
      else if (ce && tb_clk)
         div_q <= div_d;
   end

   // Overflow when every bit below the selected period boundary wraps
   always_comb
   begin
      ovf0 = time_base_cfg_q[`TBINT_B_ON] && tb_clk &&
             (div_q[`TBINT_T0_BASE-1:0] == '1) &&
             ((`TBINT_DIV_W'(div_q >> `TBINT_T0_BASE) &
               ((`TBINT_DIV_W'(1) << time_base_cfg_q[`TBINT_B_T0HI:`TBINT_B_T0LO]) - 1'b1)) ==
              ((`TBINT_DIV_W'(1) << time_base_cfg_q[`TBINT_B_T0HI:`TBINT_B_T0LO]) - 1'b1));
      ovf1 = time_base_cfg_q[`TBINT_B_ON] && tb_clk &&
             (div_q[`TBINT_T1_BASE-1:0] == '1) &&
             ((`TBINT_DIV_W'(div_q >> `TBINT_T1_BASE) &
               ((`TBINT_DIV_W'(1) << time_base_cfg_q[`TBINT_B_T1HI:`TBINT_B_T1LO]) - 1'b1)) ==
              ((`TBINT_DIV_W'(1) << time_base_cfg_q[`TBINT_B_T1HI:`TBINT_B_T1LO]) - 1'b1));
   end

   // Enables; global enable also driven by service and interrupt exit
   always_ff @(posedge mclk)
   begin
      if (!rst_n)
      begin
         global_int_enable_q     <= 1'b0;
         conversion_int_enable_q <= 1'b0;
         combined_int_enable_q   <= '0;
         tick0_int_enable_q      <= 1'b0;
         tick1_int_enable_q      <= 1'b0;
      end
      else if (ce)
      begin
         if (wr_c0)
         begin
            global_int_enable_q     <= reg_wdata[`TBINT_B_GIE];
            conversion_int_enable_q <= reg_wdata[`TBINT_B_ADE];
            combined_int_enable_q   <= reg_wdata[`TBINT_B_MF2E:`TBINT_B_MF0E];
            tick0_int_enable_q      <= reg_wdata[`TBINT_B_TICK0_INT_ENABLE];
            tick1_int_enable_q      <= reg_wdata[`TBINT_B_TICK1_INT_ENABLE];
         end
         if (svc)
            global_int_enable_q <= 1'b0;
         else if (interrupt_exit)
            global_int_enable_q <= 1'b1;
      end
   end

   // Member flag/enable registers
   always_ff @(posedge mclk)
   begin
      if (!rst_n)
      begin
         timer_period_match_enable_q <= '0;
         timer_cmpa_match_enable_q   <= '0;
         eeprom_write_int_enable_q   <= 1'b0;
         low_supply_int_enable_q     <= 1'b0;
      end
      else if (ce)
      begin
         if (wr_m0)
         begin
            timer_period_match_enable_q[0] <= reg_wdata[`TBINT_B_EN_B];
            timer_cmpa_match_enable_q[0]   <= reg_wdata[`TBINT_B_EN_A];
         end
         if (wr_m1)
         begin
            timer_period_match_enable_q[1] <= reg_wdata[`TBINT_B_EN_B];
            timer_cmpa_match_enable_q[1]   <= reg_wdata[`TBINT_B_EN_A];
         end
         if (wr_m2)
         begin
            eeprom_write_int_enable_q <= reg_wdata[`TBINT_B_EN_A];
            low_supply_int_enable_q   <= reg_wdata[`TBINT_B_EN_B];
         end
      end
   end

   // Member source flags: set wins over software clear, never auto cleared
   always_ff @(posedge mclk)
   begin
      if (!rst_n)
      begin
         timer_period_match_flag_q <= '0;
         timer_cmpa_match_flag_q   <= '0;
         eeprom_write_done_flag_q  <= 1'b0;
         low_supply_request_flag_q <= 1'b0;
      end
      else if (ce)
      begin
         if (wr_m0)
         begin
            timer_period_match_flag_q[0] <= reg_wdata[`TBINT_B_FLAG_B];
            timer_cmpa_match_flag_q[0]   <= reg_wdata[`TBINT_B_FLAG_A];
         end
         if (wr_m1)
         begin
            timer_period_match_flag_q[1] <= reg_wdata[`TBINT_B_FLAG_B];
            timer_cmpa_match_flag_q[1]   <= reg_wdata[`TBINT_B_FLAG_A];
         end
         if (wr_m2)
         begin
            eeprom_write_done_flag_q  <= reg_wdata[`TBINT_B_FLAG_A];
            low_supply_request_flag_q <= reg_wdata[`TBINT_B_FLAG_B];
         end
         if (t0_period_match)
            timer_period_match_flag_q[0] <= 1'b1;
         if (t0_cmpa_match)
            timer_cmpa_match_flag_q[0] <= 1'b1;
         if (t1_period_match)
            timer_period_match_flag_q[1] <= 1'b1;
         if (t1_cmpa_match)
            timer_cmpa_match_flag_q[1] <= 1'b1;
         if (eeprom_write_done)
            eeprom_write_done_flag_q <= 1'b1;
         if (low_supply_detect)
            low_supply_request_flag_q <= 1'b1;
      end
   end

   assign member[0] = |(timer_period_match_flag_q & timer_period_match_enable_q & 2'b01) ||
                      |(timer_cmpa_match_flag_q & timer_cmpa_match_enable_q & 2'b01);
   assign member[1] = |(timer_period_match_flag_q & timer_period_match_enable_q & 2'b10) ||
                      |(timer_cmpa_match_flag_q & timer_cmpa_match_enable_q & 2'b10);
   assign member[2] = (eeprom_write_done_flag_q && eeprom_write_int_enable_q) ||
                      (low_supply_request_flag_q && low_supply_int_enable_q);

   // Serviced flags: events win over service and software clear
   always_ff @(posedge mclk)
   begin
      if (!rst_n)
      begin
         combined_request_flag_q <= '0;
         conversion_done_flag_q  <= 1'b0;
         tick0_request_flag_q    <= 1'b0;
         tick1_request_flag_q    <= 1'b0;
      end
      else if (ce)
      begin
         if (wr_c1)
         begin
            combined_request_flag_q <= reg_wdata[`TBINT_B_MF2F:`TBINT_B_MF0F];
            conversion_done_flag_q  <= reg_wdata[`TBINT_B_ADF];
            tick0_request_flag_q    <= reg_wdata[`TBINT_B_TICK0_REQUEST_FLAG];
            tick1_request_flag_q    <= reg_wdata[`TBINT_B_TICK1_REQUEST_FLAG];
         end
         if (svc)
         begin
            case (pick)
               TBINT_SRC_MF0: combined_request_flag_q[0] <= 1'b0;
               TBINT_SRC_MF1: combined_request_flag_q[1] <= 1'b0;
               TBINT_SRC_MF2: combined_request_flag_q[2] <= 1'b0;
               TBINT_SRC_AD:  conversion_done_flag_q <= 1'b0;
               TBINT_SRC_TB0: tick0_request_flag_q <= 1'b0;
               TBINT_SRC_TB1: tick1_request_flag_q <= 1'b0;
               default: ;
            endcase
         end
         for (int i = 0; i < 3; i++)
            if (member[i])
               combined_request_flag_q[i] <= 1'b1;
         if (conversion_done)
            conversion_done_flag_q <= 1'b1;
         if (ovf0)
            tick0_request_flag_q <= 1'b1;
         if (ovf1)
            tick1_request_flag_q <= 1'b1;
      end
   end

   // Fixed priority, lowest vector first; global enable and stack gate all
   always_comb
   begin
      pick = TBINT_SRC_NONE;
      if (global_int_enable_q && !stack_full)
      begin
         if (combined_request_flag_q[0] && combined_int_enable_q[0])
            pick = TBINT_SRC_MF0;
         else if (combined_request_flag_q[1] && combined_int_enable_q[1])
            pick = TBINT_SRC_MF1;
         else if (conversion_done_flag_q && conversion_int_enable_q)
            pick = TBINT_SRC_AD;
         else if (combined_request_flag_q[2] && combined_int_enable_q[2])
            pick = TBINT_SRC_MF2;
         else if (tick0_request_flag_q && tick0_int_enable_q)
            pick = TBINT_SRC_TB0;
         else if (tick1_request_flag_q && tick1_int_enable_q)
            pick = TBINT_SRC_TB1;
      end
   end

   // Sequencer handshake: request, push return address, then vector
   always_ff @(posedge mclk)
   begin
      if (!rst_n)
      begin
         state_q    <= TBINT_ST_RUN;
         taken_q    <= TBINT_SRC_NONE;
         int_req    <= 1'b0;
         int_vector <= '0;
         push_pc    <= 1'b0;
         pop_pc     <= 1'b0;
      end
      else if (ce)
      begin
         pop_pc  <= interrupt_exit || subroutine_exit;
         push_pc <= 1'b0;
         case (state_q)
            TBINT_ST_RUN:
            begin
               int_req <= pick != TBINT_SRC_NONE && !svc;
               if (svc)
               begin
                  taken_q <= pick;
                  push_pc <= 1'b1;
                  state_q <= TBINT_ST_TAKE;
               end
               else if (sleep_enter)
                  state_q <= TBINT_ST_SLP;
            end
            TBINT_ST_TAKE:
            begin
               case (taken_q)
                  TBINT_SRC_MF0: int_vector <= `TBINT_V_MF0;
                  TBINT_SRC_MF1: int_vector <= `TBINT_V_MF1;
                  TBINT_SRC_AD:  int_vector <= `TBINT_V_AD;
                  TBINT_SRC_MF2: int_vector <= `TBINT_V_MF2;
                  TBINT_SRC_TB0: int_vector <= `TBINT_V_TB0;
                  default:       int_vector <= `TBINT_V_TB1;
               endcase
               state_q <= TBINT_ST_RUN;
            end
            TBINT_ST_SLP:
            begin
               int_req <= 1'b0;
               if (|(flags & ~flags_q))
                  state_q <= TBINT_ST_RUN;
            end
            default: state_q <= TBINT_ST_RUN;
         endcase
      end
   end

   // Wake on any flag rising, enables ignored; a preset flag cannot rise
   assign flags = {combined_request_flag_q, conversion_done_flag_q, tick0_request_flag_q,
                   tick1_request_flag_q, timer_period_match_flag_q, timer_cmpa_match_flag_q,
                   eeprom_write_done_flag_q, low_supply_request_flag_q};

   always_ff @(posedge mclk)
   begin
      if (!rst_n)
      begin
         flags_q <= '0;
         wake_up <= 1'b0;
      end
      else if (ce)
      begin
         flags_q <= flags;
         wake_up <= state_q == TBINT_ST_SLP && |(flags & ~flags_q);
      end
   end

   // Read data, one cycle after the strobe
   always_comb
   begin
      rd_d = 8'h00;
      case (reg_addr)
         `TBINT_A_TBCFG: rd_d = time_base_cfg_q;
         `TBINT_A_INTC0: rd_d = {1'b0, tick1_int_enable_q, tick0_int_enable_q, combined_int_enable_q,
                                 conversion_int_enable_q, global_int_enable_q};
         `TBINT_A_INTC1: rd_d = {2'b00, tick1_request_flag_q, tick0_request_flag_q,
                                 combined_request_flag_q, conversion_done_flag_q};
         `TBINT_A_MFI0:  rd_d = {2'b00, timer_cmpa_match_flag_q[0], timer_period_match_flag_q[0],
                                 2'b00, timer_cmpa_match_enable_q[0], timer_period_match_enable_q[0]};
         `TBINT_A_MFI1:  rd_d = {2'b00, timer_cmpa_match_flag_q[1], timer_period_match_flag_q[1],
                                 2'b00, timer_cmpa_match_enable_q[1], timer_period_match_enable_q[1]};
         `TBINT_A_MFI2:  rd_d = {2'b00, eeprom_write_done_flag_q, low_supply_request_flag_q,
                                 2'b00, eeprom_write_int_enable_q, low_supply_int_enable_q};
         `TBINT_A_STAT:  rd_d = {3'b000, taken_q, state_q};
         default:        rd_d = 8'h00;
      endcase
   end

   always_ff @(posedge mclk)
   begin
      if (!rst_n)
         reg_rdata <= 8'h00;
      else if (ce)
         reg_rdata <= reg_rd ? rd_d : 8'h00;
   end

endmodule
`default_nettype wire

// ---- dv/tbint_core_chk.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "tbint_params.svh"

module tbint_core_chk
#(
   parameter bit HAS_CRYSTAL = 1'b1
)
(
   // Clock, reset, enable
   input wire logic        mclk,
   input wire logic        rst_n,
   input wire logic        ce,
   // Register port
   input wire logic [3:0]  reg_addr,
   input wire logic [7:0]  reg_wdata,
   input wire logic        reg_wr,
   input wire logic        reg_rd,
   input wire logic [7:0]  reg_rdata,
   // Sequencer side
   input wire logic        stack_full,
   input wire logic        int_ack,
   input wire logic        interrupt_exit,
   input wire logic        subroutine_exit,
   input wire logic        int_req,
   input wire logic [11:0] int_vector,
   input wire logic        push_pc,
   input wire logic        pop_pc,
   input wire logic        wake_up,
   input wire logic        slow_crystal_low_power
);
   logic take_q;

   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_n);

   always_ff @(posedge mclk)
   begin
      take_q <= rst_n && ce && int_req && int_ack;
   end

   chk_push_take: assert property (push_pc == take_q)
      else $error("push_pc does not follow an accepted request");
   chk_take_drop: assert property (int_req && int_ack && ce |=> !int_req)
      else $error("request stays up after being taken");
   chk_vector_legal: assert property (push_pc |=> int_vector inside {`TBINT_V_MF0, `TBINT_V_MF1, `TBINT_V_AD,
      `TBINT_V_MF2, `TBINT_V_TB0, `TBINT_V_TB1}) else $error("vector not loaded after push");
   chk_full_block: assert property (stack_full [*2] |-> !int_req)
      else $error("request raised while stack full");
   chk_exit_pop: assert property ((interrupt_exit || subroutine_exit) && ce |=> pop_pc)
      else $error("return without pop");
   chk_push_pulse: assert property (push_pc |=> !push_pc)
      else $error("push longer than one cycle");
   chk_rdata_idle: assert property (!reg_rd && ce |=> reg_rdata == 8'h00)
      else $error("read data outside read answer cycle");
   chk_crystal_bit: assert property (reg_wr && ce && reg_addr == `TBINT_A_TBCFG |-> ##2
      slow_crystal_low_power == (HAS_CRYSTAL && $past(reg_wdata[3], 2)))
      else $error("crystal low power does not follow config");
   chk_wake_pulse: assert property (wake_up |=> !wake_up)
      else $error("wake longer than one cycle");

   cover property (int_req && int_ack);
   cover property (interrupt_exit ##1 pop_pc);
   cover property (wake_up);
endmodule

bind tbint_core tbint_core_chk #(.HAS_CRYSTAL(HAS_CRYSTAL)) tbint_core_chk_inst (.mclk(mclk), .rst_n(rst_n),
   .ce(ce), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
   .stack_full(stack_full), .int_ack(int_ack), .interrupt_exit(interrupt_exit), .subroutine_exit(subroutine_exit),
   .int_req(int_req), .int_vector(int_vector), .push_pc(push_pc), .pop_pc(pop_pc), .wake_up(wake_up),
   .slow_crystal_low_power(slow_crystal_low_power));
`default_nettype wire

// ---- dv/tbint_seq_model.sv ----
`timescale 1ns/1ps
`default_nettype none

module tbint_seq_model
#(
   parameter int DEPTH = 1
)
(
   // Clock and reset
   input wire logic       mclk,
   input wire logic       rst_n,
   // From the interrupt logic
   input wire logic       int_req,
   input wire logic       push_pc,
   input wire logic       pop_pc,
   // Acknowledge delay set by the bench
   input wire logic [3:0] lag,
   // To the interrupt logic
   output logic           int_ack,
   output logic           stack_full
);
   logic [3:0] wait_q;
   int         depth_q;

   always_ff @(posedge mclk)
   begin
      if (!rst_n || !int_req)
         wait_q <= 4'h0;
      else if (wait_q != 4'hF)
         wait_q <= wait_q + 4'h1;
   end

   // Only the return address is held, one slot per push
   always_ff @(posedge mclk)
   begin
      if (!rst_n)
         depth_q <= 0;
      else if (push_pc)
         depth_q <= depth_q + 1;
      else if (pop_pc && depth_q > 0)
         depth_q <= depth_q - 1;
   end

   // Full already in the push cycle so no request slips through
   assign stack_full = (depth_q + int'(push_pc)) >= DEPTH;
   assign int_ack    = int_req && (wait_q >= lag) && !stack_full;
endmodule
`default_nettype wire

// ---- dv/tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "tbint_params.svh"

module tb_top;
   import tbint_pkg::*;

   logic        mclk = 1'b0;
   logic        rst_n = 1'b0;
   logic        ce = 1'b1;
   logic [3:0]  reg_addr = 4'h0;
   logic [7:0]  reg_wdata = 8'h00;
   logic        reg_wr = 1'b0;
   logic        reg_rd = 1'b0;
   logic [7:0]  reg_rdata;
   logic        tick_clk_pulse = 1'b0;
   logic [1:0]  tick_cnt = 2'h0;
   logic [9:0]  ev = 10'h000;
   logic [3:0]  lag = 4'h0;
   logic        stack_full;
   logic        int_ack;
   logic        int_req;
   logic [11:0] int_vector;
   logic        push_pc;
   logic        pop_pc;
   logic        wake_up;
   logic        slow_lp;
   int          error_cnt = 0;
   int          compares = 0;
   logic        seen;

   always #12.5 mclk = ~mclk;

   // Dedicated tick clock: one pulse every 3 mclk
   always @(posedge mclk)
   begin
      tick_cnt <= (tick_cnt == 2'h2) ? 2'h0 : tick_cnt + 2'h1;
      tick_clk_pulse <= (tick_cnt == 2'h2);
   end

   tbint_core #(.HAS_CRYSTAL(1'b1)) tbint_core_inst (.mclk(mclk), .rst_n(rst_n), .ce(ce), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .tick_clk_pulse(tick_clk_pulse), .t0_period_match(ev[0]), .t0_cmpa_match(ev[1]), .t1_period_match(ev[2]),
      .t1_cmpa_match(ev[3]), .eeprom_write_done(ev[4]), .low_supply_detect(ev[5]), .conversion_done(ev[6]),
      .stack_full(stack_full), .int_ack(int_ack), .interrupt_exit(ev[7]), .subroutine_exit(ev[8]),
      .sleep_enter(ev[9]), .int_req(int_req), .int_vector(int_vector), .push_pc(push_pc), .pop_pc(pop_pc),
      .wake_up(wake_up), .slow_crystal_low_power(slow_lp));

   tbint_seq_model #(.DEPTH(1)) tbint_seq_model_inst (.mclk(mclk), .rst_n(rst_n), .int_req(int_req),
      .push_pc(push_pc), .pop_pc(pop_pc), .lag(lag), .int_ack(int_ack), .stack_full(stack_full));

   task automatic end_of_test();
      if (error_cnt == 0 && compares > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   task automatic chk(input string name, input logic [11:0] got, input logic [11:0] exp);
      compares++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("[FAIL] %s expected %0h seen %0h", name, exp, got);
      end
   endtask

   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge mclk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge mclk);
      reg_wr <= 1'b0;
   endtask

   task automatic rd(input logic [3:0] a, input logic [7:0] exp);
      @(posedge mclk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge mclk);
      reg_rd <= 1'b0;
      #1;
      chk("reg_rdata", {4'h0, reg_rdata}, {4'h0, exp});
   endtask

   task automatic pulse(input logic [9:0] m);
      @(posedge mclk);
      ev <= m;
      @(posedge mclk);
      ev <= 10'h000;
   endtask

   // Counts cycles until wake_up, bounded by lim
   task automatic wait_wake(input int lim, output int n);
      n = 0;
      while (wake_up !== 1'b1 && n < lim)
      begin
         @(posedge mclk);
         #1;
         n++;
      end
   endtask

   task automatic take(input logic [11:0] v);
      int n;
      n = 0;
      while (push_pc !== 1'b1 && n < 100)
      begin
         @(posedge mclk);
         #1;
         n++;
      end
      if (n >= 100)
      begin
         chk("push_pc wait", 12'h000, 12'h001);
         end_of_test();
      end
      @(posedge mclk);
      #1;
      chk("int_vector", int_vector, v);
   endtask

   task automatic period(input logic [7:0] cfg, input int exp);
      int n;
      wr(4'h0, 8'h00);
      wr(4'h2, 8'h00);
      wr(4'h0, cfg);
      pulse(10'h200);
      wait_wake(exp + 64, n);
      chk("wake delay", {11'h000, n > exp - 12 && n < exp + 8}, 12'h001);
   endtask

   initial
   begin
      int n;
      repeat (3) @(posedge mclk);
      rst_n <= 1'b1;
      rd(4'h0, 8'h37);
      wr(4'hF, 8'hFF);
      rd(4'hF, 8'h00);
      wr(4'h0, 8'h08);
      @(posedge mclk);
      #1;
      chk("crystal low power", {11'h000, slow_lp}, 12'h001);
      rd(4'h0, 8'h08);
      for (int c = 0; c < 4; c++)
         period(8'hF0 | 8'(c), 1024 << c);
      period(8'hC7, 16384);
      period(8'h97, 24576);
      period(8'hB0, 768);
      wr(4'h0, 8'h30);
      wr(4'h1, 8'h21);
      take(`TBINT_V_TB0);
      rd(4'h2, 8'h00);
      rd(4'h1, 8'h20);
      pulse(10'h080);
      rd(4'h1, 8'h21);
      wr(4'h1, 8'h00);
      // Preset flag keeps its source from waking, stopped dividers stay quiet
      wr(4'h5, 8'h10);
      pulse(10'h200);
      pulse(10'h020);
      wait_wake(1100, n);
      chk("wake while off", {11'h000, wake_up}, 12'h000);
      pulse(10'h010);
      wait_wake(6, n);
      chk("wake on rise", {11'h000, wake_up}, 12'h001);
      wr(4'h5, 8'h00);
      wr(4'h2, 8'h00);
      wr(4'h3, 8'h02);
      pulse(10'h002);
      wr(4'h1, 8'h05);
      take(`TBINT_V_MF0);
      rd(4'h3, 8'h22);
      wr(4'h3, 8'h02);
      wr(4'h2, 8'h00);
      pulse(10'h100);
      rd(4'h1, 8'h04);
      wr(4'h5, 8'h03);
      pulse(10'h030);
      wr(4'h1, 8'h11);
      take(`TBINT_V_MF2);
      rd(4'h5, 8'h33);
      wr(4'h5, 8'h03);
      wr(4'h2, 8'h00);
      pulse(10'h100);
      lag <= 4'h3;
      wr(4'h4, 8'h01);
      pulse(10'h044);
      wr(4'h1, 8'h0B);
      take(`TBINT_V_MF1);
      wr(4'h4, 8'h01);
      wr(4'h2, 8'h01);
      wr(4'h1, 8'h0B);
      seen = 1'b0;
      repeat (20)
      begin
         @(posedge mclk);
         #1;
         seen = seen | int_req;
      end
      chk("int_req while full", {11'h000, seen}, 12'h000);
      pulse(10'h080);
      take(`TBINT_V_AD);
      rd(4'h2, 8'h00);
      pulse(10'h080);
      end_of_test();
   end
endmodule
`default_nettype wire
